// ### rsi_pkg.sv
// Package of register map, field widths, reset values and timing for the reset state block.
package rsi_pkg;

  // ==========================================================================
  // Register byte offsets on the Wishbone bus
  // ==========================================================================
  localparam logic [7:0] RSI_PROC_CLK_OFS  = 8'h00;
  localparam logic [7:0] RSI_SYS_CLK_OFS   = 8'h04;
  localparam logic [7:0] RSI_CLK_OUT_OFS   = 8'h08;
  localparam logic [7:0] RSI_SUB_OSC_OFS   = 8'h0C;
  localparam logic [7:0] RSI_IRQ_REQ_OFS   = 8'h10;
  localparam logic [7:0] RSI_IRQ_EN_OFS    = 8'h14;
  localparam logic [7:0] RSI_IRQ_PRI_OFS   = 8'h18;
  localparam logic [7:0] RSI_EXT_INT_OFS   = 8'h1C;
  localparam logic [7:0] RSI_PORT_DIR_OFS  = 8'h20;
  localparam logic [7:0] RSI_PORT_LAT_OFS  = 8'h24;
  localparam logic [7:0] RSI_PULLUP_OFS    = 8'h28;
  localparam logic [7:0] RSI_BSB_OFS       = 8'h2C;
  localparam logic [7:0] RSI_STATUS_OFS    = 8'h30;
  localparam logic [7:0] RSI_STOP_OFS      = 8'h34;

  // ==========================================================================
  // Field widths and reset values
  // ==========================================================================
  localparam int RSI_NIBBLE_W   = 4;
  localparam int RSI_IRQ_N      = 10;
  localparam int RSI_EXT_N      = 3;
  localparam int RSI_DIR_N      = 3;
  localparam int RSI_PULL_N     = 2;
  localparam int RSI_BSB_N      = 4;
  localparam int RSI_PORT_W     = 16;
  localparam logic [3:0]  RSI_NIBBLE_RST = 4'h0;
  localparam logic [15:0] RSI_WORD16_RST = 16'h0000;
  localparam logic [31:0] RSI_UNMAPPED_RD = 32'h0000_0000;

  // Status bit positions.
  localparam int RSI_ST_WAITING_BIT = 0;
  localparam int RSI_ST_STOPPED_BIT = 1;
  localparam int RSI_ST_BSB_OK_BIT  = 2;

  // ==========================================================================
  // Stop release wait, 2^9 oscillator cycles at the given oscillator rate
  // ==========================================================================
  localparam int RSI_WAIT_OSC_CYCLES = 512;
  localparam int RSI_OSC_KHZ         = 2000;
  localparam int RSI_CLK_KHZ         = 40000;
  localparam int RSI_WAIT_US         = 256;
  localparam int RSI_WAIT_CLKS       = RSI_WAIT_US * (RSI_CLK_KHZ / 1000);

  typedef enum logic [1:0] {RSI_RUN, RSI_STOP, RSI_WAIT} rsi_state_e;

endpackage

// ### rsi_wait_timer.sv
// Stop release wait timer with a build-time selectable length.
`timescale 1ns/10ps
`default_nettype none

module rsi_wait_timer
  import rsi_pkg::*;
#(
  parameter int          WAIT_CLKS = RSI_WAIT_CLKS,
  parameter bit          NO_WAIT   = 1'b0
)(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      start_i,
  output logic           done_o,
  output logic           busy_o
);

  localparam int CNT_W = $clog2(WAIT_CLKS + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WAIT_CLKS - 1);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             busy_q;
  logic             busy_d;
  logic             done_q;
  logic             done_d;

  // ==========================================================================
  // Counter
  // ==========================================================================
  always_comb
  begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start_i && !busy_q)
    begin
      if (NO_WAIT)
      begin
        done_d = 1'b1;
      end
      else
      begin
        cnt_d  = CNT_LOAD;
        busy_d = 1'b1;
      end
    end
    else if (busy_q)
    begin
      if (cnt_q == '0)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;
  assign busy_o = busy_q;

endmodule

`default_nettype wire

// ### rsi_reset_state.sv
// Reset state initializer: clock, interrupt, port and bit buffer registers behind Wishbone.
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Any reset zeroes processor clock, system clock and sub-oscillator controls.
// - Any reset zeroes the clock output select register.
// - Any reset zeroes all interrupt request and enable flags.
// - Any reset zeroes the interrupt priority select register.
// - Any reset zeroes the three external interrupt configuration registers.
// - Reset turns port buffers off, clears latches and direction groups.
// - Any reset zeroes both pull-up select registers.
// - Bit buffers kept on standby reset, undefined after reset in operation.
// - Interrupt release of stop inserts a selectable wait or none.
module rsi_reset_state
  import rsi_pkg::*;
#(
  parameter int          WAIT_CLKS = RSI_WAIT_CLKS,
  parameter bit          NO_WAIT   = 1'b0
)(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [RSI_IRQ_N-1:0]  irq_event_i,
  output logic      [RSI_PORT_W-1:0] port_out_o,
  output logic      [RSI_PORT_W-1:0] port_oe_n_o,
  output logic                       stopped_o
);

  logic [3:0]               proc_clk_q, proc_clk_d;
  logic [3:0]               sys_clk_q, sys_clk_d;
  logic [3:0]               clk_out_q, clk_out_d;
  logic [3:0]               sub_osc_q, sub_osc_d;
  logic [RSI_IRQ_N-1:0]     irq_req_q, irq_req_d;
  logic [RSI_IRQ_N-1:0]     irq_en_q, irq_en_d;
  logic [3:0]               irq_pri_q, irq_pri_d;
  logic [3:0]               ext_cfg_q [RSI_EXT_N];
  logic [3:0]               ext_cfg_d [RSI_EXT_N];
  logic [3:0]               dir_q [RSI_DIR_N];
  logic [3:0]               dir_d [RSI_DIR_N];
  logic [RSI_PORT_W-1:0]    lat_q, lat_d;
  logic [3:0]               pull_q [RSI_PULL_N];
  logic [3:0]               pull_d [RSI_PULL_N];
  logic [3:0]               bsb_q [RSI_BSB_N];
  logic [3:0]               bsb_d [RSI_BSB_N];
  logic                     bsb_ok_q, bsb_ok_d;
  rsi_state_e               state_q, state_d;
  logic                     ack_q, ack_d;
  logic [31:0]              rdat_q, rdat_d;
  logic [RSI_PORT_W-1:0]    oe_n_q, oe_n_d;
  logic                     stop_q, stop_d;
  logic                     wr;
  logic                     rd;
  logic                     wait_start;
  logic                     wait_done;
  logic                     wait_busy;
  logic [3:0]               wn;
  logic                     rst_seen_q;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
  assign wn = wb_dat_i[3:0];

  // ==========================================================================
  // Stop standby control
  // ==========================================================================
  always_comb
  begin
    state_d    = state_q;
    wait_start = 1'b0;
    case (state_q)
      RSI_RUN:
      begin
        if (wr && wb_adr_i == RSI_STOP_OFS && wb_dat_i[0])
        begin
          state_d = RSI_STOP;
        end
      end
      RSI_STOP:
      begin
        if (|(irq_event_i & irq_en_q))
        begin
          wait_start = 1'b1;
          state_d    = RSI_WAIT;
        end
      end
      RSI_WAIT:
      begin
        if (wait_done)
        begin
          state_d = RSI_RUN;
        end
      end
      default:
      begin
        state_d = RSI_RUN;
      end
    endcase
    stop_d = (state_d != RSI_RUN);
  end

  rsi_wait_timer #(
    .WAIT_CLKS (WAIT_CLKS),
    .NO_WAIT   (NO_WAIT)
  ) u_wait (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (wait_start),
    .done_o  (wait_done),
    .busy_o  (wait_busy)
  );

  // ==========================================================================
  // Register writes
  // ==========================================================================
  always_comb
  begin
    proc_clk_d = proc_clk_q;
    sys_clk_d  = sys_clk_q;
    clk_out_d  = clk_out_q;
    sub_osc_d  = sub_osc_q;
    irq_en_d   = irq_en_q;
    irq_pri_d  = irq_pri_q;
    lat_d      = lat_q;
    ext_cfg_d  = ext_cfg_q;
    dir_d      = dir_q;
    pull_d     = pull_q;
    bsb_d      = bsb_q;
    bsb_ok_d   = bsb_ok_q;
    irq_req_d  = irq_req_q;
    // Software clears a request by writing one; a new event in the same cycle wins.
    if (wr && wb_adr_i == RSI_IRQ_REQ_OFS)
    begin
      irq_req_d = irq_req_q & ~wb_dat_i[RSI_IRQ_N-1:0];
    end
    irq_req_d = irq_req_d | irq_event_i;
    if (wr)
    begin
      if (wb_adr_i == RSI_PROC_CLK_OFS)
      begin
        proc_clk_d = wn;
      end
      else if (wb_adr_i == RSI_SYS_CLK_OFS)
      begin
        sys_clk_d = wn;
      end
      else if (wb_adr_i == RSI_CLK_OUT_OFS)
      begin
        clk_out_d = wn;
      end
      else if (wb_adr_i == RSI_SUB_OSC_OFS)
      begin
        sub_osc_d = wn;
      end
      else if (wb_adr_i == RSI_IRQ_EN_OFS)
      begin
        irq_en_d = wb_dat_i[RSI_IRQ_N-1:0];
      end
      else if (wb_adr_i == RSI_IRQ_PRI_OFS)
      begin
        irq_pri_d = wn;
      end
      else if (wb_adr_i == RSI_EXT_INT_OFS)
      begin
        for (int i = 0; i < RSI_EXT_N; i++)
        begin
          ext_cfg_d[i] = wb_dat_i[4*i +: 4];
        end
      end
      else if (wb_adr_i == RSI_PORT_DIR_OFS)
      begin
        for (int i = 0; i < RSI_DIR_N; i++)
        begin
          dir_d[i] = wb_dat_i[4*i +: 4];
        end
      end
      else if (wb_adr_i == RSI_PORT_LAT_OFS)
      begin
        lat_d = wb_dat_i[RSI_PORT_W-1:0];
      end
      else if (wb_adr_i == RSI_PULLUP_OFS)
      begin
        for (int i = 0; i < RSI_PULL_N; i++)
        begin
          pull_d[i] = wb_dat_i[4*i +: 4];
        end
      end
      else if (wb_adr_i == RSI_BSB_OFS)
      begin
        for (int i = 0; i < RSI_BSB_N; i++)
        begin
          bsb_d[i] = wb_dat_i[4*i +: 4];
        end
        bsb_ok_d = 1'b1;
      end
    end
    // Direction groups a, b, c enable bits 0-3, 4-7 and 8-15 of the port.
    oe_n_d = ~{{2{dir_d[2]}}, dir_d[1], dir_d[0]};
  end

  // ==========================================================================
  // Read mux and acknowledge
  // ==========================================================================
  always_comb
  begin
    ack_d  = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d = RSI_UNMAPPED_RD;
    if (rd)
    begin
      if (wb_adr_i == RSI_PROC_CLK_OFS)
      begin
        rdat_d = {28'h0, proc_clk_q};
      end
      else if (wb_adr_i == RSI_SYS_CLK_OFS)
      begin
        rdat_d = {28'h0, sys_clk_q};
      end
      else if (wb_adr_i == RSI_CLK_OUT_OFS)
      begin
        rdat_d = {28'h0, clk_out_q};
      end
      else if (wb_adr_i == RSI_SUB_OSC_OFS)
      begin
        rdat_d = {28'h0, sub_osc_q};
      end
      else if (wb_adr_i == RSI_IRQ_REQ_OFS)
      begin
        rdat_d = {22'h0, irq_req_q};
      end
      else if (wb_adr_i == RSI_IRQ_EN_OFS)
      begin
        rdat_d = {22'h0, irq_en_q};
      end
      else if (wb_adr_i == RSI_IRQ_PRI_OFS)
      begin
        rdat_d = {28'h0, irq_pri_q};
      end
      else if (wb_adr_i == RSI_EXT_INT_OFS)
      begin
        rdat_d = {20'h0, ext_cfg_q[2], ext_cfg_q[1], ext_cfg_q[0]};
      end
      else if (wb_adr_i == RSI_PORT_DIR_OFS)
      begin
        rdat_d = {20'h0, dir_q[2], dir_q[1], dir_q[0]};
      end
      else if (wb_adr_i == RSI_PORT_LAT_OFS)
      begin
        rdat_d = {16'h0, lat_q};
      end
      else if (wb_adr_i == RSI_PULLUP_OFS)
      begin
        rdat_d = {24'h0, pull_q[1], pull_q[0]};
      end
      else if (wb_adr_i == RSI_BSB_OFS)
      begin
        rdat_d = {16'h0, bsb_q[3], bsb_q[2], bsb_q[1], bsb_q[0]};
      end
      else if (wb_adr_i == RSI_STATUS_OFS)
      begin
        rdat_d = {29'h0, bsb_ok_q, state_q == RSI_STOP, wait_busy};
      end
      else if (wb_adr_i == RSI_STOP_OFS)
      begin
        rdat_d = {31'h0, stop_q};
      end
    end
  end

  // ==========================================================================
  // State registers
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      proc_clk_q <= RSI_NIBBLE_RST;
      sys_clk_q  <= RSI_NIBBLE_RST;
      sub_osc_q  <= RSI_NIBBLE_RST;
      clk_out_q  <= RSI_NIBBLE_RST;
      irq_req_q  <= '0;
      irq_en_q   <= '0;
      irq_pri_q  <= RSI_NIBBLE_RST;
      for (int i = 0; i < RSI_EXT_N; i++)
      begin
        ext_cfg_q[i] <= RSI_NIBBLE_RST;
      end
      for (int i = 0; i < RSI_DIR_N; i++)
      begin
        dir_q[i] <= RSI_NIBBLE_RST;
      end
      lat_q    <= RSI_WORD16_RST;
      oe_n_q   <= ~RSI_WORD16_RST;
      for (int i = 0; i < RSI_PULL_N; i++)
      begin
        pull_q[i] <= RSI_NIBBLE_RST;
      end
      // Buffers keep their contents; only in-operation reset marks them undefined.
      // A reset held for several cycles judges by the state of its first cycle only.
      bsb_ok_q   <= bsb_ok_q && (state_q != RSI_RUN || rst_seen_q);
      rst_seen_q <= 1'b1;
      state_q  <= RSI_RUN;
      stop_q   <= 1'b0;
      ack_q    <= 1'b0;
      rdat_q   <= RSI_UNMAPPED_RD;
    end
    else
    begin
      proc_clk_q <= proc_clk_d;
      sys_clk_q  <= sys_clk_d;
      sub_osc_q  <= sub_osc_d;
      clk_out_q  <= clk_out_d;
      irq_req_q  <= irq_req_d;
      irq_en_q   <= irq_en_d;
      irq_pri_q  <= irq_pri_d;
      ext_cfg_q  <= ext_cfg_d;
      dir_q      <= dir_d;
      lat_q      <= lat_d;
      oe_n_q     <= oe_n_d;
      pull_q     <= pull_d;
      bsb_ok_q   <= bsb_ok_d;
      rst_seen_q <= 1'b0;
      state_q    <= state_d;
      stop_q     <= stop_d;
      ack_q      <= ack_d;
      rdat_q     <= rdat_d;
    end
  end

  // The buffers have no reset so that a standby reset cannot disturb them.
  always_ff @(posedge clk_i)
  begin
    if (!rst_i)
    begin
      bsb_q <= bsb_d;
    end
  end

  assign wb_dat_o    = rdat_q;
  assign wb_ack_o    = ack_q;
  assign port_out_o  = lat_q;
  assign port_oe_n_o = oe_n_q;
  assign stopped_o   = stop_q;

endmodule

`default_nettype wire

// ### rsi_monitor.sv
// Checker of bus timing, reset values and stop wait of the reset state block.
`timescale 1ns/10ps
`default_nettype none
module rsi_monitor
  import rsi_pkg::*;
#(
  parameter int WAIT_CLKS = RSI_WAIT_CLKS,
  parameter bit NO_WAIT   = 1'b0
)(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [9:0]  irq_event_i,
  input wire logic [15:0] port_out_o,
  input wire logic [15:0] port_oe_n_o,
  input wire logic        stopped_o
);
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  // Counts stopped cycles since the last event, so that idle stop time is not taken for wait.
  // Saturates so that a long stop never wraps to a short count.
  logic [15:0] run_q;
  logic [15:0] run_d;
  always_comb
  begin
    if (!stopped_o || irq_event_i != 10'h000)
    begin
      run_d = 16'h0000;
    end
    else if (run_q != 16'hFFFF)
    begin
      run_d = run_q + 16'h0001;
    end
    else
    begin
      run_d = run_q;
    end
  end
  always_ff @(posedge clk_i)
  begin
    run_q <= rst_i ? 16'h0000 : run_d;
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_stop_req;
    s_take ##0 (wb_we_i && wb_sel_i[0] && wb_dat_i[0] && wb_adr_i == RSI_STOP_OFS);
  endsequence
  a_rst_values: assert property (disable iff (1'b0) rst_i |=>
    port_oe_n_o == 16'hFFFF && port_out_o == 16'h0000 && !stopped_o && !wb_ack_o
    && wb_dat_o == 32'h0000_0000) else $error("outputs not at reset values");
  a_ack_follows: assert property (s_take |=> wb_ack_o) else $error("request not acked");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (wb_ack_o |=> wb_dat_o == 32'h0000_0000) else $error("stale data");
  a_unmapped_zero: assert property (s_take ##0 (wb_adr_i > RSI_STOP_OFS) |=>
    wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  a_stop_entry: assert property (s_stop_req |-> ##[1:2] stopped_o)
    else $error("stop not entered");
  a_wait_length: assert property ($fell(stopped_o) |-> (NO_WAIT || run_q >= WAIT_CLKS))
    else $error("stop wait too short");
  a_no_wait_short: assert property ($fell(stopped_o) |-> (!NO_WAIT || run_q <= 16'h0002))
    else $error("stop release without wait too slow");
endmodule
bind rsi_reset_state rsi_monitor #(.WAIT_CLKS(WAIT_CLKS), .NO_WAIT(NO_WAIT)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_event_i(irq_event_i), .port_out_o(port_out_o), .port_oe_n_o(port_oe_n_o),
  .stopped_o(stopped_o));
`default_nettype wire

// ### test_rsi_reset_state.sv
// Self-checking testbench of the reset state block.
`timescale 1ns/10ps
`default_nettype none
module test_rsi_reset_state
  import rsi_pkg::*;
;
  localparam int WAIT = 8;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, stopped_o;
  logic        stopped_nw;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, seed;
  logic [9:0]  irq_event_i, ev;
  logic [15:0] port_out_o, port_oe_n_o;
  int          num_errors, n_compared, cnt, k;
  logic [7:0]  ofs [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24,
                            8'h28, 8'h2C};
  logic [31:0] msk [11] = '{32'hF, 32'hF, 32'hF, 32'hF, 32'h3FF, 32'hF, 32'hFFF, 32'hFFF,
                            32'hFFFF, 32'hFF, 32'hFFFF};
  logic [31:0] wr [11];

  rsi_reset_state #(.WAIT_CLKS(WAIT), .NO_WAIT(1'b0)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_event_i(irq_event_i), .port_out_o(port_out_o), .port_oe_n_o(port_oe_n_o),
    .stopped_o(stopped_o));
  // Second build with the stop release wait switched off, fed the same stimulus.
  rsi_reset_state #(.WAIT_CLKS(WAIT), .NO_WAIT(1'b1)) DUT_NW (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(), .wb_ack_o(),
    .irq_event_i(irq_event_i), .port_out_o(), .port_oe_n_o(), .stopped_o(stopped_nw));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Direction bit 1 means output, and the enable is active low.
  function automatic logic [31:0] exp_oe(input logic [31:0] d);
    return {16'h0000, ~{d[11:8], d[11:8], d[7:4], d[3:0]}};
  endfunction
  task automatic test_done();
    $display("compared %0d wrong %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (wb_ack_o !== 1'b1 && i < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i == 20)
    begin
      num_errors++;
      test_done();
    end
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check({16'h0000, port_oe_n_o}, 32'hFFFF);
    check({16'h0000, port_out_o}, 32'h0);
    rst_i <= 1'b0;
  endtask
  task automatic all_zero();
    for (int j = 0; j < 10; j++)
    begin
      wb(1'b0, ofs[j], 32'h0, 4'hF, rd);
      check(rd, 32'h0);
    end
    wb(1'b0, RSI_IRQ_REQ_OFS, 32'h0, 4'hF, rd);
    check(rd, 32'h0);
    check({16'h0000, port_oe_n_o}, exp_oe(32'h0));
  endtask

  // ==========================================================================
  // Stimulus
  // ==========================================================================
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    irq_event_i = 10'h000;
    num_errors = 0;
    n_compared = 0;
    seed = 32'h41D9A3AB;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    all_zero();
    $display("test power_up done");
    for (k = 0; k < 11; k++)
    begin
      seed = lfsr(seed);
      wr[k] = (k == 8) ? 32'hFFFF : seed & msk[k];
      wb(1'b1, ofs[k], wr[k], 4'hF, rd);
    end
    ev = seed[9:0] | 10'h200;
    @(posedge clk_i) irq_event_i <= ev;
    @(posedge clk_i) irq_event_i <= 10'h000;
    wb(1'b1, 8'h00, ~wr[0], 4'h0, rd);
    for (k = 0; k < 11; k++)
    begin
      wb(1'b0, ofs[k], 32'h0, 4'hF, rd);
      check(rd, wr[k]);
    end
    check({16'h0000, port_out_o}, wr[8]);
    check({16'h0000, port_oe_n_o}, exp_oe(wr[7]));
    wb(1'b0, RSI_IRQ_REQ_OFS, 32'h0, 4'hF, rd);
    check(rd, {22'h0, ev});
    wb(1'b1, RSI_IRQ_REQ_OFS, {22'h0, ev}, 4'hF, rd);
    wb(1'b0, RSI_IRQ_REQ_OFS, 32'h0, 4'hF, rd);
    check(rd, 32'h0);
    wb(1'b0, 8'h3C, 32'h0, 4'hF, rd);
    check(rd, 32'h0);
    do_reset();
    all_zero();
    wb(1'b0, RSI_STATUS_OFS, 32'h0, 4'hF, rd);
    check(rd & 32'h4, 32'h0);
    $display("test run_reset done");
    wr[10] = lfsr(seed) & 32'hFFFF;
    wb(1'b1, RSI_BSB_OFS, wr[10], 4'hF, rd);
    wb(1'b1, RSI_STOP_OFS, 32'h1, 4'hF, rd);
    do_reset();
    wb(1'b0, RSI_BSB_OFS, 32'h0, 4'hF, rd);
    check(rd, wr[10]);
    wb(1'b0, RSI_STATUS_OFS, 32'h0, 4'hF, rd);
    check(rd & 32'h4, 32'h4);
    $display("test standby_reset done");
    wb(1'b1, RSI_IRQ_EN_OFS, 32'h1, 4'hF, rd);
    wb(1'b1, RSI_STOP_OFS, 32'h1, 4'hF, rd);
    @(posedge clk_i) irq_event_i <= 10'h002;
    @(posedge clk_i) irq_event_i <= 10'h000;
    repeat (20) @(posedge clk_i);
    check({31'h0, stopped_o}, 32'h1);
    check({31'h0, stopped_nw}, 32'h1);
    @(posedge clk_i) irq_event_i <= 10'h001;
    @(posedge clk_i) irq_event_i <= 10'h000;
    cnt = 0;
    k = 0;
    while (stopped_o === 1'b1 && cnt < 50)
    begin
      @(posedge clk_i);
      cnt++;
      if (stopped_nw === 1'b1)
      begin
        k = cnt;
      end
    end
    check({31'h0, cnt >= WAIT - 1 && cnt <= WAIT + 4}, 32'h1);
    check({31'h0, k <= 2}, 32'h1);
    if (cnt == 50)
      test_done();
    $display("test stop_wait done");
    test_done();
  end
endmodule
`default_nettype wire
